// [rtl/trgseq_regs.svh]
// register offsets, field positions, reset values and codes of the trigger sequencer
`ifndef TRGSEQ_REGS_SVH
`define TRGSEQ_REGS_SVH

`define TRGSEQ_OFF_CTRL 8'h00
`define TRGSEQ_OFF_STAT 8'h04
`define TRGSEQ_OFF_BTE 8'h08
`define TRGSEQ_OFF_HOLD 8'h0c
`define TRGSEQ_OFF_ADJ 8'h10
`define TRGSEQ_OFF_LIT0 8'h14
`define TRGSEQ_OFF_C0LIM 8'h18
`define TRGSEQ_OFF_C1LIM 8'h1c
`define TRGSEQ_OFF_T0LIM 8'h20
`define TRGSEQ_OFF_T1LIM 8'h24
`define TRGSEQ_OFF_SDLIM 8'h28
`define TRGSEQ_OFF_ADCSEL 8'h2c
`define TRGSEQ_OFF_LCNT0 8'h30
`define TRGSEQ_OFF_LCNT1 8'h34
`define TRGSEQ_QUEUE_BASE 2'h1

`define TRGSEQ_CLK_LSB 13
`define TRGSEQ_DIV_LSB 8
`define TRGSEQ_PWD_LSB 4
`define TRGSEQ_WDT_LSB 0
`define TRGSEQ_ST_RUN 0
`define TRGSEQ_ST_SWT 1
`define TRGSEQ_ST_WERR 2
`define TRGSEQ_ST_BUSY 3
`define TRGSEQ_ST_PTR_LSB 8

`define TRGSEQ_REG_RST 16'h0000
`define TRGSEQ_WDT_BASE 16'h0008
`define TRGSEQ_RESP_OKAY 2'h0
`define TRGSEQ_RESP_SLVERR 2'h2

`define TRGSEQ_CMD_CTRL 4'h0
`define TRGSEQ_CMD_ADDCP 4'h1
`define TRGSEQ_OPT_SD_OFF 4'h2
`define TRGSEQ_OPT_SD_ON 4'h6
`define TRGSEQ_OPT_WAIT_T0 4'h8
`define TRGSEQ_OPT_WAIT_T1 4'h9
`define TRGSEQ_OPT_WAIT_SWT 4'hb
`define TRGSEQ_OPT_SEL_C0 4'hc
`define TRGSEQ_OPT_SEL_C1 4'hd
`define TRGSEQ_OPT_SEL_L0 4'he
`define TRGSEQ_OPT_TRIG 4'hf

`define TRGSEQ_SRC_PER 3'h0
`define TRGSEQ_SRC_OSC 3'h1
`define TRGSEQ_SRC_ADC 3'h2
`define TRGSEQ_SRC_T1 3'h3
`define TRGSEQ_SRC_T2 3'h4
`define TRGSEQ_SRC_T3 3'h5

`endif

// [rtl/trgseq_pkg.sv]
// types shared by the trigger sequencer files
package trgseq_pkg;
	typedef enum logic [2:0] {
		S_IDLE,
		S_FETCH,
		S_EXEC,
		S_WAIT_T0,
		S_WAIT_T1,
		S_WAIT_SWT,
		S_DELAY
	} trgseq_state_t;

	typedef struct packed {
		logic [15:0] ctrl;
		logic run;
		logic swt;
		logic wdt_err;
		logic sd_en;
		logic [15:0] bte;
		logic [15:0] hold;
		logic [15:0] adj;
		logic [15:0] lit0;
		logic [15:0] c0lim;
		logic [15:0] c1lim;
		logic [15:0] t0lim;
		logic [15:0] t1lim;
		logic [15:0] sdlim;
		logic [15:0] adcsel;
		logic [15:0] lcnt0;
		logic [15:0] lcnt1;
	} trgseq_regs_t;

	typedef struct packed {
		trgseq_state_t state;
		logic [3:0] ptr;
		logic [4:0] div_cnt;
		logic [15:0] t_cnt;
		logic [15:0] sd_cnt;
		logic [15:0] wd_cnt;
		logic [3:0] pw_cnt;
		logic [15:0] trig;
		logic swt_prev;
		logic busy;
	} trgseq_seq_t;
endpackage

// [rtl/trgseq_step_mem.sv]
// step queue memory, registered read port
module trgseq_step_mem (
	input wire logic aclk,
	input wire logic we,
	input wire logic [3:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [3:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem [0:15];

	// contents are data, not control: left unreset to map onto plain storage
	always_ff @(posedge aclk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

// [rtl/trgseq_top.sv]
// trigger sequencer with axi4-lite register slave
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`include "trgseq_regs.svh"
// Behaviour
// RULE_01 - control option 0010 stops the step delay, 0110 restarts it; others reserved
// RULE_02 - options 1000/1001 start timer 0/1 and stall until it matches its limit
// RULE_03 - option 1011 stalls until the software trigger bit rises from zero to one
// RULE_04 - options 1100/1101 copy loop counter 0/1 into adc channel select
// RULE_05 - option 1110 copies literal 0 into adc channel select
// RULE_06 - option 1111 pulses every trigger output enabled in broadcast enable
// RULE_07 - add options 0000..0101 add adjust value to the six limit/literal registers
// RULE_08 - copy options 1000..1101 load hold value into the six limit/literal registers
// RULE_09 - reserved commands and options use their slot but change nothing
// RULE_10 - trigger pulses last pulse-width field plus one module clocks
// RULE_11 - watchdog field 000 disables, 001..111 give 8 to 512 module clocks
// RULE_12 - prescaler divides the module clock by field plus one
// RULE_13 - clock source field picks peripheral, oscillator, adc or timer clocks
// RULE_14 - a wait outlasting the watchdog stops the sequence and flags an error
module trgseq_top
	import trgseq_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic osc_tick,
	input wire logic adc_tick,
	input wire logic tmr1_tick,
	input wire logic tmr2_tick,
	input wire logic tmr3_tick,
	input wire logic awvalid,
	input wire logic [7:0] awaddr,
	output logic awready,
	input wire logic wvalid,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic wready,
	output logic bvalid,
	output logic [1:0] bresp,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic [7:0] araddr,
	output logic arready,
	output logic rvalid,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic rready,
	output logic [15:0] trigger_out,
	output logic [15:0] adc_channel_select,
	output logic seq_busy
);
	trgseq_regs_t regs_q, regs_d;
	trgseq_seq_t seq_q, seq_d;
	logic awready_q, awready_d, bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic wen, ren, waddr_ok, q_we;
	logic src_tick, mod_tick, step_done;
	logic [2:0] clk_sel, wdt_sel;
	logic [4:0] div_sel;
	logic [3:0] pwd_sel, cls, opt;
	logic [15:0] wdt_lim;
	logic [7:0] step;
	logic [31:0] rd_val;
	logic rd_ok;

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	assign clk_sel = regs_q.ctrl[`TRGSEQ_CLK_LSB +: 3];
	assign div_sel = regs_q.ctrl[`TRGSEQ_DIV_LSB +: 5];
	assign pwd_sel = regs_q.ctrl[`TRGSEQ_PWD_LSB +: 4];
	assign wdt_sel = regs_q.ctrl[`TRGSEQ_WDT_LSB +: 3];
	assign cls = step[7:4];
	assign opt = step[3:0];

	// write taken only when address and data are both offered
	assign wen = awready_q && awvalid && wvalid;
	assign ren = arready_q && arvalid;
	// a misaligned queue address is refused, so it must not land in the queue either
	assign q_we = wen && (awaddr[7:6] == `TRGSEQ_QUEUE_BASE) && (awaddr[1:0] == 2'h0) &&
		wstrb[0];

	trgseq_step_mem u_mem (
		.aclk(aclk),
		.we(q_we),
		.waddr(awaddr[5:2]),
		.wdata(wdata[7:0]),
		.raddr(seq_q.ptr),
		.rdata(step)
	);

	always_comb
	begin
		case (clk_sel) // RULE_13
			`TRGSEQ_SRC_PER: src_tick = 1'b1;
			`TRGSEQ_SRC_OSC: src_tick = osc_tick;
			`TRGSEQ_SRC_ADC: src_tick = adc_tick;
			`TRGSEQ_SRC_T1: src_tick = tmr1_tick;
			`TRGSEQ_SRC_T2: src_tick = tmr2_tick;
			`TRGSEQ_SRC_T3: src_tick = tmr3_tick;
			// reserved sources give no ticks, so the timers stand still
			default: src_tick = 1'b0;
		endcase
		mod_tick = src_tick && (seq_q.div_cnt == div_sel); // RULE_12
		wdt_lim = `TRGSEQ_WDT_BASE << (wdt_sel - 3'h1); // RULE_11
	end

	always_comb
	begin
		waddr_ok = 1'b1;
		rd_ok = 1'b1;
		rd_val = 32'h00000000;
		case (araddr)
			`TRGSEQ_OFF_CTRL: rd_val = 32'(regs_q.ctrl);
			`TRGSEQ_OFF_STAT: rd_val = 32'({seq_q.ptr, 4'h0, seq_q.busy, regs_q.wdt_err,
				regs_q.swt, regs_q.run});
			`TRGSEQ_OFF_BTE: rd_val = 32'(regs_q.bte);
			`TRGSEQ_OFF_HOLD: rd_val = 32'(regs_q.hold);
			`TRGSEQ_OFF_ADJ: rd_val = 32'(regs_q.adj);
			`TRGSEQ_OFF_LIT0: rd_val = 32'(regs_q.lit0);
			`TRGSEQ_OFF_C0LIM: rd_val = 32'(regs_q.c0lim);
			`TRGSEQ_OFF_C1LIM: rd_val = 32'(regs_q.c1lim);
			`TRGSEQ_OFF_T0LIM: rd_val = 32'(regs_q.t0lim);
			`TRGSEQ_OFF_T1LIM: rd_val = 32'(regs_q.t1lim);
			`TRGSEQ_OFF_SDLIM: rd_val = 32'(regs_q.sdlim);
			`TRGSEQ_OFF_ADCSEL: rd_val = 32'(regs_q.adcsel);
			`TRGSEQ_OFF_LCNT0: rd_val = 32'(regs_q.lcnt0);
			`TRGSEQ_OFF_LCNT1: rd_val = 32'(regs_q.lcnt1);
			default:
			begin
				// the step queue is write-only; its read port belongs to the sequencer
				rd_ok = (araddr[7:6] == `TRGSEQ_QUEUE_BASE) && (araddr[1:0] == 2'h0);
			end
		endcase
		case (awaddr)
			`TRGSEQ_OFF_CTRL, `TRGSEQ_OFF_STAT, `TRGSEQ_OFF_BTE, `TRGSEQ_OFF_HOLD,
			`TRGSEQ_OFF_ADJ, `TRGSEQ_OFF_LIT0, `TRGSEQ_OFF_C0LIM, `TRGSEQ_OFF_C1LIM,
			`TRGSEQ_OFF_T0LIM, `TRGSEQ_OFF_T1LIM, `TRGSEQ_OFF_SDLIM, `TRGSEQ_OFF_LCNT0,
			`TRGSEQ_OFF_LCNT1: waddr_ok = 1'b1;
			default: waddr_ok = (awaddr[7:6] == `TRGSEQ_QUEUE_BASE) && (awaddr[1:0] == 2'h0);
		endcase
	end

	always_comb
	begin
		awready_d = awvalid && wvalid && !awready_q && !bvalid_q;
		bvalid_d = bvalid_q && !bready;
		bresp_d = bresp_q;
		if (wen)
		begin
			bvalid_d = 1'b1;
			bresp_d = waddr_ok ? `TRGSEQ_RESP_OKAY : `TRGSEQ_RESP_SLVERR;
		end
		arready_d = arvalid && !arready_q && !rvalid_q;
		rvalid_d = rvalid_q && !rready;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (ren)
		begin
			rvalid_d = 1'b1;
			rdata_d = rd_ok ? rd_val : 32'h00000000;
			rresp_d = rd_ok ? `TRGSEQ_RESP_OKAY : `TRGSEQ_RESP_SLVERR;
		end
	end

	always_comb
	begin
		regs_d = regs_q;
		seq_d = seq_q;
		step_done = 1'b0;

		// software writes first; sequencer updates below override in the same cycle
		if (wen)
		begin
			case (awaddr)
				// bit 3 is unused and reads zero
				`TRGSEQ_OFF_CTRL: regs_d.ctrl = merge16(regs_q.ctrl, wdata, wstrb) & 16'hfff7;
				`TRGSEQ_OFF_STAT:
				begin
					if (wstrb[0])
					begin
						regs_d.run = wdata[`TRGSEQ_ST_RUN];
						regs_d.swt = wdata[`TRGSEQ_ST_SWT];
						if (wdata[`TRGSEQ_ST_WERR])
						begin
							regs_d.wdt_err = 1'b0;
						end
					end
				end
				`TRGSEQ_OFF_BTE: regs_d.bte = merge16(regs_q.bte, wdata, wstrb);
				`TRGSEQ_OFF_HOLD: regs_d.hold = merge16(regs_q.hold, wdata, wstrb);
				`TRGSEQ_OFF_ADJ: regs_d.adj = merge16(regs_q.adj, wdata, wstrb);
				`TRGSEQ_OFF_LIT0: regs_d.lit0 = merge16(regs_q.lit0, wdata, wstrb);
				`TRGSEQ_OFF_C0LIM: regs_d.c0lim = merge16(regs_q.c0lim, wdata, wstrb);
				`TRGSEQ_OFF_C1LIM: regs_d.c1lim = merge16(regs_q.c1lim, wdata, wstrb);
				`TRGSEQ_OFF_T0LIM: regs_d.t0lim = merge16(regs_q.t0lim, wdata, wstrb);
				`TRGSEQ_OFF_T1LIM: regs_d.t1lim = merge16(regs_q.t1lim, wdata, wstrb);
				`TRGSEQ_OFF_SDLIM: regs_d.sdlim = merge16(regs_q.sdlim, wdata, wstrb);
				`TRGSEQ_OFF_LCNT0: regs_d.lcnt0 = merge16(regs_q.lcnt0, wdata, wstrb);
				`TRGSEQ_OFF_LCNT1: regs_d.lcnt1 = merge16(regs_q.lcnt1, wdata, wstrb);
				default: regs_d.ctrl = regs_q.ctrl;
			endcase
		end

		if (src_tick) // RULE_12
		begin
			seq_d.div_cnt = mod_tick ? 5'h00 : 5'(seq_q.div_cnt + 5'h01);
		end

		// trigger pulse: loaded on the step, held for field plus one module clocks
		if ((seq_q.trig != 16'h0000) && mod_tick) // RULE_10
		begin
			if (seq_q.pw_cnt == 4'h0)
			begin
				seq_d.trig = 16'h0000;
			end
			else
			begin
				seq_d.pw_cnt = 4'(seq_q.pw_cnt - 4'h1);
			end
		end

		case (seq_q.state)
			S_IDLE:
			begin
				if (regs_q.run)
				begin
					seq_d.ptr = 4'h0;
					seq_d.state = S_FETCH;
				end
			end
			S_FETCH: seq_d.state = S_EXEC;
			S_EXEC:
			begin
				seq_d.ptr = 4'(seq_q.ptr + 4'h1);
				seq_d.t_cnt = 16'h0000;
				seq_d.wd_cnt = 16'h0000;
				step_done = 1'b1;
				if (cls == `TRGSEQ_CMD_CTRL)
				begin
					case (opt)
						`TRGSEQ_OPT_SD_OFF: regs_d.sd_en = 1'b0; // RULE_01
						`TRGSEQ_OPT_SD_ON: regs_d.sd_en = 1'b1; // RULE_01
						`TRGSEQ_OPT_WAIT_T0: // RULE_02
						begin
							step_done = 1'b0;
							seq_d.state = S_WAIT_T0;
						end
						`TRGSEQ_OPT_WAIT_T1: // RULE_02
						begin
							step_done = 1'b0;
							seq_d.state = S_WAIT_T1;
						end
						`TRGSEQ_OPT_WAIT_SWT: // RULE_03
						begin
							step_done = 1'b0;
							seq_d.state = S_WAIT_SWT;
						end
						`TRGSEQ_OPT_SEL_C0: regs_d.adcsel = regs_q.lcnt0; // RULE_04
						`TRGSEQ_OPT_SEL_C1: regs_d.adcsel = regs_q.lcnt1; // RULE_04
						`TRGSEQ_OPT_SEL_L0: regs_d.adcsel = regs_q.lit0; // RULE_05
						`TRGSEQ_OPT_TRIG: // RULE_06
						begin
							seq_d.trig = regs_q.bte;
							seq_d.pw_cnt = pwd_sel; // RULE_10
						end
						default: regs_d.sd_en = regs_q.sd_en; // RULE_09
					endcase
				end
				else if (cls == `TRGSEQ_CMD_ADDCP)
				begin
					// option bit 3 picks copy of hold over add of adjust
					case (opt[2:0]) // RULE_07 RULE_08
						3'h0: regs_d.c0lim = opt[3] ? regs_q.hold : 16'(regs_q.c0lim + regs_q.adj);
						3'h1: regs_d.c1lim = opt[3] ? regs_q.hold : 16'(regs_q.c1lim + regs_q.adj);
						3'h2: regs_d.t0lim = opt[3] ? regs_q.hold : 16'(regs_q.t0lim + regs_q.adj);
						3'h3: regs_d.t1lim = opt[3] ? regs_q.hold : 16'(regs_q.t1lim + regs_q.adj);
						3'h4: regs_d.sdlim = opt[3] ? regs_q.hold : 16'(regs_q.sdlim + regs_q.adj);
						3'h5: regs_d.lit0 = opt[3] ? regs_q.hold : 16'(regs_q.lit0 + regs_q.adj);
						default: regs_d.lit0 = regs_q.lit0; // RULE_09
					endcase
				end
			end
			S_WAIT_T0:
			begin
				if (seq_q.t_cnt == regs_q.t0lim) // RULE_02
				begin
					step_done = 1'b1;
				end
				else if (mod_tick)
				begin
					seq_d.t_cnt = 16'(seq_q.t_cnt + 16'h0001);
				end
			end
			S_WAIT_T1:
			begin
				if (seq_q.t_cnt == regs_q.t1lim) // RULE_02
				begin
					step_done = 1'b1;
				end
				else if (mod_tick)
				begin
					seq_d.t_cnt = 16'(seq_q.t_cnt + 16'h0001);
				end
			end
			S_WAIT_SWT:
			begin
				if (regs_q.swt && !seq_q.swt_prev) // RULE_03
				begin
					step_done = 1'b1;
				end
			end
			S_DELAY:
			begin
				if (seq_q.sd_cnt == regs_q.sdlim)
				begin
					seq_d.state = S_FETCH;
				end
				else if (mod_tick)
				begin
					seq_d.sd_cnt = 16'(seq_q.sd_cnt + 16'h0001);
				end
			end
			default: seq_d.state = S_IDLE;
		endcase

		if (step_done)
		begin
			seq_d.sd_cnt = 16'h0000;
			seq_d.state = regs_d.sd_en ? S_DELAY : S_FETCH;
		end

		// watchdog only guards the three wait steps
		if ((seq_q.state == S_WAIT_T0) || (seq_q.state == S_WAIT_T1) ||
			(seq_q.state == S_WAIT_SWT))
		begin
			if (mod_tick)
			begin
				seq_d.wd_cnt = 16'(seq_q.wd_cnt + 16'h0001);
			end
			if ((wdt_sel != 3'h0) && (seq_q.wd_cnt >= wdt_lim) && !step_done) // RULE_11
			begin
				regs_d.wdt_err = 1'b1; // RULE_14
				regs_d.run = 1'b0; // RULE_14
				seq_d.state = S_IDLE; // RULE_14
			end
		end

		// clearing run aborts the sequence at once
		if (!regs_q.run)
		begin
			seq_d.state = S_IDLE;
		end
		seq_d.swt_prev = regs_q.swt;
		seq_d.busy = (seq_d.state != S_IDLE);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			regs_q <= '0;
			seq_q <= '0;
			awready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `TRGSEQ_RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `TRGSEQ_RESP_OKAY;
		end
		else
		begin
			regs_q <= regs_d;
			seq_q <= seq_d;
			awready_q <= awready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	assign awready = awready_q;
	assign wready = awready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign trigger_out = seq_q.trig;
	assign adc_channel_select = regs_q.adcsel;
	assign seq_busy = seq_q.busy;
endmodule

// [tb/trgseq_rx_model.sv]
// trigger receiver standing in for the adc and other trigger users
module trgseq_rx_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [15:0] trigger_out,
	input wire logic [15:0] adc_channel_select,
	output logic [15:0] seen_bits_q,
	output logic [15:0] seen_sel_q,
	output logic [7:0] width_q
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] run_q;

	// the adc latches its channel on the first cycle of a trigger
	always_ff @(posedge aclk)
	begin
		if (!aresetn || trigger_out == 16'h0000)
			run_q <= 8'h00;
		else
			run_q <= run_q + 8'h01;
		if (aresetn && trigger_out != 16'h0000 && run_q == 8'h00)
		begin
			seen_bits_q <= trigger_out;
			seen_sel_q <= adc_channel_select;
		end
		if (aresetn && trigger_out != 16'h0000)
			width_q <= run_q + 8'h01;
	end
endmodule

// [tb/trgseq_top_asserts.sv]
// bus and sequencer checks bound to the trigger sequencer top
module trgseq_top_asserts (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic [1:0] bresp,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic [31:0] rdata,
	input wire logic rready,
	input wire logic [15:0] trigger_out,
	input wire logic [15:0] adc_channel_select,
	input wire logic seq_busy
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	aw_w_pair_a: assert property (awready == wready)
		else $error("awready and wready differ");
	aw_cause_a: assert property (awready |-> $past(awvalid && wvalid))
		else $error("write taken without both valids");
	aw_pulse_a: assert property (awready |=> !awready)
		else $error("awready longer than one cycle");
	b_follow_a: assert property (awready && awvalid |=> bvalid)
		else $error("no write response after handshake");
	b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	r_follow_a: assert property (arready && arvalid |=> rvalid)
		else $error("no read data after handshake");
	r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	r_upper_a: assert property (rvalid |-> rdata[31:16] == 16'h0000)
		else $error("read upper half not zero");
	trig_busy_a: assert property ((trigger_out != 16'h0000) &&
		($past(trigger_out) == 16'h0000) |-> $past(seq_busy))
		else $error("trigger raised while idle");
	sel_busy_a: assert property ($changed(adc_channel_select) |-> $past(seq_busy))
		else $error("adc select changed while idle");
endmodule

bind trgseq_top trgseq_top_asserts u_asserts (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bresp(bresp),
	.bready(bready), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rdata(rdata),
	.rready(rready), .trigger_out(trigger_out), .adc_channel_select(adc_channel_select),
	.seq_busy(seq_busy));

// [tb/tb.sv]
// self-checking bench for the trigger sequencer
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic osc_tick = 1'b0, adc_tick = 1'b0, tmr1_tick = 1'b0;
	logic tmr2_tick = 1'b0, tmr3_tick = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, seq_busy;
	logic [7:0] awaddr, araddr, width;
	logic [7:0] tick_q = 8'h00;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [15:0] trigger_out, adc_channel_select, seen_bits, seen_sel;
	logic [7:0] lim_addr [6];
	int fail_count, cmp_count;

	trgseq_top dut (
		.aclk(aclk), .aresetn(aresetn), .osc_tick(osc_tick), .adc_tick(adc_tick),
		.tmr1_tick(tmr1_tick), .tmr2_tick(tmr2_tick), .tmr3_tick(tmr3_tick),
		.awvalid(awvalid), .awaddr(awaddr), .awready(awready), .wvalid(wvalid),
		.wdata(wdata), .wstrb(wstrb), .wready(wready), .bvalid(bvalid), .bresp(bresp),
		.bready(bready), .arvalid(arvalid), .araddr(araddr), .arready(arready),
		.rvalid(rvalid), .rdata(rdata), .rresp(rresp), .rready(rready),
		.trigger_out(trigger_out), .adc_channel_select(adc_channel_select),
		.seq_busy(seq_busy)
	);
	trgseq_rx_model rx (
		.aclk(aclk), .aresetn(aresetn), .trigger_out(trigger_out),
		.adc_channel_select(adc_channel_select), .seen_bits_q(seen_bits),
		.seen_sel_q(seen_sel), .width_q(width)
	);

	initial
	begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// source ticks at unlike rates, adc and timer 2 sharing one rate at unlike phases, so a wrong source select shows up
	always @(posedge aclk)
	begin
		tick_q <= tick_q + 8'h01;
		osc_tick <= tick_q[1:0] == 2'h3;
		adc_tick <= tick_q[2:0] == 3'h7;
		tmr1_tick <= tick_q[0];
		tmr2_tick <= tick_q[2:0] == 3'h3;
		tmr3_tick <= tick_q[4:0] == 5'h1f;
	end

	task stop_test();
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// 0 awready, 1 bvalid, 2 arready, 3 rvalid
	function automatic logic pick(input int k);
		case (k)
			0: pick = awready;
			1: pick = bvalid;
			2: pick = arready;
			default: pick = rvalid;
		endcase
	endfunction

	task automatic wait_hi(input int k);
		int n;
		n = 0;
		@(posedge aclk);
		while (pick(k) !== 1'b1 && n < 200)
		begin
			n++;
			@(posedge aclk);
		end
		chk(32'(pick(k)), 32'h1);
		if (pick(k) !== 1'b1)
			stop_test();
	endtask

	// response ready held back a cycle so the slave must keep its answer
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= d;
		wait_hi(0);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		@(posedge aclk);
		bready <= 1'b1;
		wait_hi(1);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hffff_ffff, input logic [1:0] er = 2'h0);
		arvalid <= 1'b1;
		araddr <= a;
		wait_hi(2);
		arvalid <= 1'b0;
		@(posedge aclk);
		rready <= 1'b1;
		wait_hi(3);
		rready <= 1'b0;
		chk(rdata & m, e);
		chk({30'h0, rresp}, {30'h0, er});
	endtask

	task automatic prog(input int i, input logic [7:0] c);
		wr(8'h40 + 8'(4 * i), {24'h0, c});
	endtask

	task automatic t_regs();
		for (int i = 0; i < 14; i++)
			rd(8'(4 * i), 32'h0);
		wr(8'h18, 32'hffff_abcd);
		rd(8'h18, 32'h0000_abcd);
		wr(8'h38, 32'h1, 2'h2);
		rd(8'h38, 32'h0, 32'hffff_ffff, 2'h2);
	endtask

	// program ends on a trigger wait so the result is frozen when read
	task automatic t_math();
		wr(8'h0c, 32'h0123);
		wr(8'h10, 32'h0010);
		for (int i = 0; i < 6; i++)
		begin
			prog(i, 8'h18 + 8'(i));
			prog(i + 6, 8'h10 + 8'(i));
		end
		prog(12, 8'h16);
		prog(13, 8'h1e);
		prog(14, 8'h28);
		prog(15, 8'h0b);
		wr(8'h04, 32'h1);
		repeat (60) @(posedge aclk);
		for (int i = 0; i < 6; i++)
			rd(lim_addr[i], 32'h0133);
		// pointer already names the next entry, wrapped to 0
		rd(8'h04, 32'h0009, 32'h0f0f);
		wr(8'h04, 32'h0);
		repeat (3) @(posedge aclk);
		chk(32'(seq_busy), 32'h0);
	endtask

	task automatic t_trig();
		logic [7:0] p [7] = '{8'h0c, 8'h0b, 8'h0d, 8'h0b, 8'h0e, 8'h0f, 8'h0b};
		wr(8'h30, 32'h5);
		wr(8'h34, 32'h9);
		wr(8'h14, 32'h7);
		wr(8'h08, 32'h00a5);
		wr(8'h00, 32'h0030);
		for (int i = 0; i < 7; i++)
			prog(i, p[i]);
		wr(8'h04, 32'h1);
		repeat (10) @(posedge aclk);
		chk(32'(adc_channel_select), 32'h5);
		wr(8'h04, 32'h3);
		repeat (10) @(posedge aclk);
		chk(32'(adc_channel_select), 32'h9);
		wr(8'h04, 32'h1);
		wr(8'h04, 32'h3);
		repeat (20) @(posedge aclk);
		chk(32'(adc_channel_select), 32'h7);
		chk(32'(seen_bits), 32'h00a5);
		chk(32'(width), 32'h4);
		chk(32'(seen_sel), 32'h7);
		wr(8'h04, 32'h0);
	endtask

	// oscillator source halved: one module tick per eight bus clocks
	task automatic t_wdt();
		wr(8'h20, 32'h5);
		prog(0, 8'h08);
		prog(1, 8'h0b);
		wr(8'h00, 32'h2100);
		wr(8'h04, 32'h1);
		repeat (24) @(posedge aclk);
		rd(8'h04, 32'h0109, 32'h0f0d);
		repeat (60) @(posedge aclk);
		rd(8'h04, 32'h0209, 32'h0f0d);
		wr(8'h04, 32'h0);
		wr(8'h20, 32'h14);
		wr(8'h00, 32'h2101);
		wr(8'h04, 32'h1);
		repeat (100) @(posedge aclk);
		rd(8'h04, 32'h0004, 32'h000d);
		wr(8'h04, 32'h4);
		rd(8'h04, 32'h0, 32'h000d);
		wr(8'h00, 32'h2100);
		wr(8'h04, 32'h1);
		repeat (100) @(posedge aclk);
		rd(8'h04, 32'h0009, 32'h000d);
	endtask

	task automatic t_reset();
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk(32'(seq_busy), 32'h0);
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
	endtask

	// timer 1 source ticks every other cycle, so each delayed step takes about forty cycles
	task automatic t_delay();
		wr(8'h28, 32'h14);
		wr(8'h30, 32'h3);
		wr(8'h00, 32'h6000);
		prog(0, 8'h06);
		prog(1, 8'h0c);
		prog(2, 8'h02);
		prog(3, 8'h0b);
		wr(8'h04, 32'h1);
		repeat (20) @(posedge aclk);
		chk(32'(adc_channel_select), 32'h0);
		repeat (40) @(posedge aclk);
		chk(32'(adc_channel_select), 32'h3);
		rd(8'h04, 32'h0209, 32'h0f0d);
		repeat (40) @(posedge aclk);
		rd(8'h04, 32'h0409, 32'h0f0d);
		wr(8'h04, 32'h0);
	endtask

	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		fail_count = 0;
		cmp_count = 0;
		lim_addr = '{8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h14};
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_math();
		t_trig();
		t_wdt();
		t_reset();
		t_delay();
		stop_test();
	end
endmodule
